// ===== logic/ccms_divider.sv
// Divider that turns a rate select code into a one-cycle clock enable pulse.
`timescale 1ns/100ps
`default_nettype none
module ccms_divider
  import ccms_pkg::*;
#(
  parameter int DIV_W = CCMS_DIV_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [2:0]       sel_i,
  output logic                  en_o
);
  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] mask;
  logic             en_ff;

  // Code n fires once every two to the n cycles; code 0 fires every cycle, the full input rate.
  assign mask = DIV_W'((1 << sel_i) - 1);

  // Free-running counter; a change of code takes effect at once, so one period may be short.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + DIV_W'(1);
    end
  end

  // Registered enable pulse.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_ff <= 1'b0;
    end else begin
      en_ff <= ((cnt_ff & mask) == mask);
    end
  end

  assign en_o = en_ff;
endmodule
`default_nettype wire

// ===== logic/ccms_pkg.sv
// Package with register map, field layout, reset values and carrier types for the clock control block.
package ccms_pkg;
  // Register byte addresses on the 24-bit register space.
  localparam logic [23:0] CCMS_ADDR_CLK_SEL   = 24'hFFFDC4;
  localparam logic [23:0] CCMS_ADDR_MOD_STOP  = 24'hFFFDC8;
  // Clock select field positions.
  localparam int CCMS_SYS_LSB = 8;
  localparam int CCMS_PER_LSB = 4;
  localparam int CCMS_BUS_LSB = 0;
  localparam int CCMS_SEL_W   = 3;
  // Module stop field positions.
  localparam int CCMS_ALL_STOP_EN_BIT = 15;
  localparam int CCMS_EXT_DMA_BIT  = 14;
  localparam int CCMS_TIMER_BIT    = 0;
  localparam int CCMS_NUM_MODULES  = 15;
  // Select codes: 000 runs at four times the input clock, 001 at twice.
  localparam logic [2:0] CCMS_SEL_X4 = 3'h0;
  localparam logic [2:0] CCMS_SEL_X2 = 3'h1;
  // Reset values.
  localparam logic [15:0] CCMS_CLK_SEL_RST  = 16'h0010;
  localparam logic [15:0] CCMS_MOD_STOP_RST = 16'h0000;
  // Modules whose stop bits must all be set before the all-clock-stop mode may start.
  localparam logic [14:0] CCMS_CTRL_MASK = 15'h4001;
  // Writable bits of each register.
  localparam logic [15:0] CCMS_CLK_SEL_WMASK  = 16'h0777;
  localparam logic [15:0] CCMS_MOD_STOP_WMASK = 16'hC001;
  localparam int CCMS_DIV_W = 8;

  // Decoded clock select fields.
  typedef struct packed {
    logic [2:0] system_sel;
    logic [2:0] peripheral_sel;
    logic [2:0] bus_sel;
  } ccms_clk_sel_s;

  // Clock enables handed out to the rest of the chip.
  typedef struct packed {
    logic system_en;
    logic peripheral_en;
    logic bus_en;
  } ccms_clk_en_s;
endpackage

// ===== logic/ccms_top.sv
// Clock select and module stop control with an Avalon-MM register slave.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module ccms_top
  import ccms_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [23:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        sleep_i,
  input  wire logic        wake_i,
  output logic             system_clk_en_o,
  output logic             dma_clk_en_o,
  output logic             peripheral_clk_en_o,
  output logic             bus_clk_en_o,
  output logic             bus_io_clk_en_o,
  output logic [14:0]      module_clk_en_o,
  output logic [14:0]      module_stop_o,
  output logic             ext_dma_clk_en_o,
  output logic             timer_unit_clk_en_o,
  output logic             all_clock_stopped_o
);
  logic [15:0]   clock_frequency_select_ff;
  logic [15:0]   module_stop_control_a_ff;
  logic          ack_ff;
  logic [31:0]   rdata_ff;
  logic          all_stop_ff;
  logic          req;
  logic          hit_sel;
  logic          hit_stop;
  logic          wr_take;
  logic [15:0]   be_mask;
  logic [15:0]   nxt_rdata;
  logic          all_ctrl_stopped;
  logic          all_clock_stop_enable;
  ccms_clk_sel_s sel;
  ccms_clk_en_s  en;
  logic [2:0]    sel_vec [3];
  logic [2:0]    en_vec;

  // Bus side decode; the slave always inserts exactly one wait cycle so reads come from a flop.
  assign req               = avs_read_i | avs_write_i;
  assign hit_sel           = (avs_address_i == CCMS_ADDR_CLK_SEL);
  assign hit_stop          = (avs_address_i == CCMS_ADDR_MOD_STOP);
  assign avs_waitrequest_o = req & ~ack_ff;
  assign wr_take           = avs_write_i & ack_ff;
  assign be_mask           = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign avs_readdata_o    = rdata_ff;

  // Acknowledge toggles high for one cycle per request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read data mux; unmapped addresses read as zero and the upper half is always zero.
  always_comb begin
    nxt_rdata = 16'h0000;
    if (hit_sel) begin
      nxt_rdata = clock_frequency_select_ff;
    end else if (hit_stop) begin
      nxt_rdata = module_stop_control_a_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h00000000;
    end else if (avs_read_i & ~ack_ff) begin
      rdata_ff <= {16'h0000, nxt_rdata};
    end
  end

  // Clock select register; only the three select fields are writable.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_frequency_select_ff <= CCMS_CLK_SEL_RST;
    end else if (wr_take & hit_sel) begin
      clock_frequency_select_ff <= (clock_frequency_select_ff & ~(be_mask & CCMS_CLK_SEL_WMASK)) |
                                   (avs_writedata_i[15:0] & be_mask & CCMS_CLK_SEL_WMASK);
    end
  end

  // Module stop register; a 1 stops a module, a 0 releases it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      module_stop_control_a_ff <= CCMS_MOD_STOP_RST;
    end else if (wr_take & hit_stop) begin
      module_stop_control_a_ff <= (module_stop_control_a_ff & ~(be_mask & CCMS_MOD_STOP_WMASK)) |
                                  (avs_writedata_i[15:0] & be_mask & CCMS_MOD_STOP_WMASK);
    end
  end

  // Field extraction into the carrier struct.
  assign sel.system_sel     = clock_frequency_select_ff[CCMS_SYS_LSB +: CCMS_SEL_W];
  assign sel.peripheral_sel = clock_frequency_select_ff[CCMS_PER_LSB +: CCMS_SEL_W];
  assign sel.bus_sel        = clock_frequency_select_ff[CCMS_BUS_LSB +: CCMS_SEL_W];
  assign sel_vec[0]         = sel.system_sel;
  assign sel_vec[1]         = sel.peripheral_sel;
  assign sel_vec[2]         = sel.bus_sel;

  // One divider per clock domain; clk_i stands for the four-times rate.
  // Separate counters cost a few flops; all three reset together and count in step, so the domains share one phase.
  for (genvar g = 0; g < 3; g++) begin : g_div
    ccms_divider ccms_divider_i (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .sel_i   (sel_vec[g]),
      .en_o    (en_vec[g])
    );
  end

  assign en.system_en     = en_vec[0];
  assign en.peripheral_en = en_vec[1];
  assign en.bus_en        = en_vec[2];

  // All-module-clock-stop entry on sleep; the set wins over a wake in the same cycle.
  assign all_clock_stop_enable = module_stop_control_a_ff[CCMS_ALL_STOP_EN_BIT];
  assign all_ctrl_stopped      = ((module_stop_control_a_ff[CCMS_NUM_MODULES-1:0] & CCMS_CTRL_MASK) == CCMS_CTRL_MASK);

  // The stop state is a plain level; a user must raise wake_i or clear the enable bit to leave it.
  // Clearing the enable also ends the state, so software cannot strand the port clocks.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      all_stop_ff <= 1'b0;
    end else if (sleep_i & all_clock_stop_enable & all_ctrl_stopped) begin
      all_stop_ff <= 1'b1;
    end else if (wake_i | ~all_clock_stop_enable) begin
      all_stop_ff <= 1'b0;
    end
  end

  // Clock enables fanned out; a stopped module simply never sees its enable.
  assign system_clk_en_o     = en.system_en;
  assign dma_clk_en_o        = en.system_en & ~module_stop_control_a_ff[CCMS_EXT_DMA_BIT];
  assign peripheral_clk_en_o = en.peripheral_en;
  assign bus_clk_en_o        = en.bus_en;
  assign bus_io_clk_en_o     = en.bus_en & ~all_stop_ff;
  assign module_stop_o       = module_stop_control_a_ff[CCMS_NUM_MODULES-1:0];
  assign module_clk_en_o     = {CCMS_NUM_MODULES{en.peripheral_en}} &
                               ~module_stop_control_a_ff[CCMS_NUM_MODULES-1:0];
  assign ext_dma_clk_en_o    = module_clk_en_o[CCMS_EXT_DMA_BIT];
  assign timer_unit_clk_en_o = module_clk_en_o[CCMS_TIMER_BIT];
  assign all_clock_stopped_o = all_stop_ff;

  // Sequences shared by the checks below.
  sequence s_stop_write(bit v);
    wr_take && hit_stop && avs_byteenable_i[0] && (avs_writedata_i[CCMS_TIMER_BIT] == v);
  endsequence

  sequence s_sleep_entry;
    sleep_i && all_clock_stop_enable && all_ctrl_stopped;
  endsequence

  a_sys_full_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel.system_sel == CCMS_SEL_X4) [*3] |-> system_clk_en_o)
    else $error("system enable missing at code 000");
  a_per_half_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel.peripheral_sel == CCMS_SEL_X2) [*4] |-> (peripheral_clk_en_o != $past(peripheral_clk_en_o)))
    else $error("peripheral enable not at half rate for code 001");
  a_bus_full_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel.bus_sel == CCMS_SEL_X4) [*3] |-> bus_clk_en_o)
    else $error("bus enable missing at code 000");
  a_stop_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_stop_write(1'b1) |=> (module_stop_o[CCMS_TIMER_BIT] && !timer_unit_clk_en_o))
    else $error("timer unit not stopped after writing 1");
  a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_stop_write(1'b0) |=> !module_stop_o[CCMS_TIMER_BIT] ##1 (timer_unit_clk_en_o || !peripheral_clk_en_o))
    else $error("timer unit not released after writing 0");
  a_sleep_enters: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sleep_entry |=> all_clock_stopped_o && !bus_io_clk_en_o)
    else $error("all-clock-stop not entered on sleep");
  a_stop_en_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !all_clock_stop_enable |=> !all_clock_stopped_o)
    else $error("all-clock-stop held with enable cleared");
  a_no_entry_running: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sleep_i && !all_ctrl_stopped && !all_clock_stopped_o) |=> !all_clock_stopped_o)
    else $error("all-clock-stop entered while a module runs");
  a_dma_mapping: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    module_stop_o[CCMS_EXT_DMA_BIT] |-> (!ext_dma_clk_en_o && !dma_clk_en_o))
    else $error("external DMA clock running while stopped");
  a_bus_one_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(avs_read_i) && !ack_ff) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read not answered after one wait cycle");

  // Leaving the stop mode: a wake with no fresh entry in the same cycle.
  sequence s_wake_exit;
    wake_i && !(sleep_i && all_clock_stop_enable && all_ctrl_stopped);
  endsequence

  a_wake_exits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_exit |=> !all_clock_stopped_o)
    else $error("all-clock-stop not left on wake");
  a_stopped_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (all_clock_stopped_o && !wake_i && all_clock_stop_enable) |=> all_clock_stopped_o)
    else $error("all-clock-stop dropped without wake");
  a_timer_runs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!module_stop_o[CCMS_TIMER_BIT] && peripheral_clk_en_o) |-> timer_unit_clk_en_o)
    else $error("timer unit enable missing while released");
  a_bus_half_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel.bus_sel == CCMS_SEL_X2) [*4] |-> (bus_clk_en_o != $past(bus_clk_en_o)))
    else $error("bus enable not at half rate for code 001");
  a_read_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (avs_read_i && !ack_ff && hit_sel) |=> (avs_readdata_o[15:0] == $past(clock_frequency_select_ff)))
    else $error("clock select read data wrong");
endmodule
`default_nettype wire

// ===== verif/test_ccms_top.sv
// Self-checking random testbench for the clock select and module stop block.
`timescale 1ns/100ps
`default_nettype none
module test_ccms_top;
  import ccms_pkg::*;
  logic        clk_i            = 1'b0;
  logic        rst_n_i          = 1'b0;
  logic [23:0] avs_address_i    = 24'h000000;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'h3;
  logic        sleep_i          = 1'b0;
  logic        wake_i           = 1'b0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        system_clk_en_o;
  logic        dma_clk_en_o;
  logic        peripheral_clk_en_o;
  logic        bus_clk_en_o;
  logic        bus_io_clk_en_o;
  logic [14:0] module_clk_en_o;
  logic [14:0] module_stop_o;
  logic        ext_dma_clk_en_o;
  logic        timer_unit_clk_en_o;
  logic        all_clock_stopped_o;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cnt [8];
  logic [31:0] q;
  logic [15:0] cs;
  logic [15:0] ms;

  ccms_top ccms_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sleep_i(sleep_i), .wake_i(wake_i),
    .system_clk_en_o(system_clk_en_o), .dma_clk_en_o(dma_clk_en_o),
    .peripheral_clk_en_o(peripheral_clk_en_o), .bus_clk_en_o(bus_clk_en_o),
    .bus_io_clk_en_o(bus_io_clk_en_o), .module_clk_en_o(module_clk_en_o), .module_stop_o(module_stop_o),
    .ext_dma_clk_en_o(ext_dma_clk_en_o), .timer_unit_clk_en_o(timer_unit_clk_en_o),
    .all_clock_stopped_o(all_clock_stopped_o));

  // A 25 MHz clock, 40 ns period.
  always #20 clk_i = ~clk_i;

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One Avalon cycle, started just after a rising edge; the request stands until the edge at which
  // waitrequest is seen low. Design flops change by non-blocking assignment, so values read here are that edge's.
  task automatic bus(input logic wr, input logic [23:0] a, input logic [15:0] d, output logic [31:0] r);
    int k;
    r               = 32'h00000000;
    avs_address_i   <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 20) begin
      error_cnt++;
      $display("MISMATCH %0t bus answer missing", $time);
      summarize();
    end else begin
      r = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  // Expected pulses in a 128-cycle window for a rate code.
  function automatic int rate(input logic [2:0] c);
    return 128 >> c;
  endfunction

  // Counts enable pulses over 128 cycles; a whole number of periods for every code.
  task automatic count_en();
    for (int k = 0; k < 8; k++) cnt[k] = 0;
    repeat (128) begin
      @(negedge clk_i);
      cnt[0] += int'(system_clk_en_o);
      cnt[1] += int'(peripheral_clk_en_o);
      cnt[2] += int'(bus_clk_en_o);
      cnt[3] += int'(dma_clk_en_o);
      cnt[4] += int'(bus_io_clk_en_o);
      cnt[5] += int'(ext_dma_clk_en_o);
      cnt[6] += int'(timer_unit_clk_en_o);
      cnt[7] += int'(module_clk_en_o[7]);
    end
    // Return on a rising edge so the next bus request starts where the master may change signals.
    @(posedge clk_i);
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    #400000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end

  // Main sequence: reset values, random select and stop settings, then sleep entry and exit.
  initial begin
    void'($urandom(32'h828A));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, CCMS_ADDR_CLK_SEL, 16'h0000, q);
    chk(q, 32'h00000010, "clock select reset");
    bus(1'b0, CCMS_ADDR_MOD_STOP, 16'h0000, q);
    chk(q, 32'h00000000, "module stop reset");
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      cs = 16'($urandom);
      ms = 16'($urandom);
      if (i == 0) begin
        cs = 16'h0010;
        ms = 16'h0000;
      end
      if (i == 1) begin
        cs = 16'hFFFF;
        ms = 16'h7FFF;
      end
      bus(1'b1, CCMS_ADDR_CLK_SEL, cs, q);
      bus(1'b1, CCMS_ADDR_MOD_STOP, ms, q);
      bus(1'b1, 24'hFFFDC6, ~cs, q);
      bus(1'b0, CCMS_ADDR_CLK_SEL, 16'h0000, q);
      chk(q, {16'h0000, cs & CCMS_CLK_SEL_WMASK}, "clock select readback");
      bus(1'b0, CCMS_ADDR_MOD_STOP, 16'h0000, q);
      chk(q, {16'h0000, ms & CCMS_MOD_STOP_WMASK}, "module stop readback");
      bus(1'b0, 24'hFFFDC6, 16'h0000, q);
      chk(q, 32'h00000000, "unmapped read");
      chk(32'(module_stop_o), 32'(ms[14:0] & CCMS_CTRL_MASK), "stop outputs");
      count_en();
      chk(cnt[0], rate(cs[10:8]), "system rate");
      chk(cnt[1], rate(cs[6:4]), "peripheral rate");
      chk(cnt[2], rate(cs[2:0]), "bus rate");
      chk(cnt[3], ms[14] ? 0 : rate(cs[10:8]), "dma rate");
      chk(cnt[4], rate(cs[2:0]), "bus port rate");
      chk(cnt[5], ms[14] ? 0 : rate(cs[6:4]), "ext dma module");
      chk(cnt[6], ms[0] ? 0 : rate(cs[6:4]), "timer module");
      chk(cnt[7], rate(cs[6:4]), "unstoppable module");
    end
    $display("test rates and stops done");
    // Only the last case has the enable and both controlled stop bits set.
    for (int i = 0; i < 3; i++) begin
      ms = (i == 0) ? 16'h4001 : (i == 1) ? 16'h8001 : 16'hC001;
      bus(1'b1, CCMS_ADDR_MOD_STOP, ms, q);
      sleep_i <= 1'b1;
      @(posedge clk_i);
      sleep_i <= 1'b0;
      @(negedge clk_i);
      chk(32'(all_clock_stopped_o), 32'(i == 2), "sleep entry");
      count_en();
      chk(cnt[4], (i == 2) ? 0 : rate(cs[2:0]), "bus port gating");
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      @(negedge clk_i);
      chk(32'(all_clock_stopped_o), 32'h00000000, "wake exit");
      @(posedge clk_i);
    end
    $display("test sleep done");
    summarize();
  end
endmodule
`default_nettype wire
